// ### hdl/acp_ctrl.sv
/*
 * acp_ctrl: register file, input selection, result buffer and interrupt of the sample/convert block.
 * Assumes a converter core on clk_i that returns a result with a one-cycle ready pulse,
 * same-clock timer/event trigger pulses, and an asynchronous external trigger pin.
 */
// Functional notes
// RULE1 - with auto start off, writing one to the sample bit starts acquisition.
// RULE2 - with trigger code 000, writing zero to the sample bit ends acquisition and starts conversion.
// RULE3 - the sample bit reads one while acquiring and zero while holding.
// RULE4 - the reference field picks supply/ground or external pins; codes with the top bit set act as 000.
// RULE5 - software keeps reserved bit 12 of the setup register at zero.
// RULE6 - with scan on, selector A steps through the channels enabled in the scan select register.
// RULE7 - with scan off, selector A uses the fixed channel A select bits.
// RULE8 - in split mode the half flag reads one while words 8 to 15 are being filled.
// RULE9 - in split mode the half flag reads zero while words 0 to 7 are being filled.
// RULE10 - field value N raises the interrupt after every N+1 sequences.
// RULE11 - with split mode set the buffer is two eight-word halves.
// RULE12 - with split mode clear the buffer is one sixteen-word store filled from word 0.
// RULE13 - with alternate mode set conversions alternate A then B, starting with A.
// RULE14 - with alternate mode clear every conversion uses selector A.
// RULE15 - the half flag only means something in split mode.
// RULE16 - code 000 ends sampling only by software, code 111 by an internal counter.
// RULE17 - the done flag sets at conversion end, clears at the next start or by software without side effects.
`timescale 1ns/1ps
module acp_ctrl
    import acp_pkg::*;
#(
    parameter int AUTO_SAMPLE_CYCLES = AUTO_SAMPLE_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              trig_pin_i,
    input  wire logic              timer_trig_i,
    input  wire logic              event_trig_i,
    input  wire logic              conv_ready_i,
    input  wire logic [RES_W-1:0]  conv_result_i,
    output logic                   sampling_o,
    output logic                   converting_o,
    output logic [CH_W-1:0]        chan_pos_o,
    output logic                   use_sel_b_o,
    output logic                   ref_pos_ext_o,
    output logic                   ref_neg_ext_o,
    output logic                   irq_o
);
    acp_seq_if sq ();

    // software state
    logic [2:0]           trig_src;
    logic                 auto_start;
    logic                 done;
    logic [2:0]           ref_sel;
    logic                 scan_en;
    logic [3:0]           seq_per_irq;
    logic                 split_mode;
    logic                 alt_mode;
    logic [DATA_W-1:0]    scan_sel;
    logic [CH_W-1:0]      chan_a;
    logic [CH_W-1:0]      chan_b;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;

    // running state
    logic [CH_W-1:0]      scan_ptr;
    logic                 on_sel_b;
    logic [3:0]           seq_cnt;
    logic [PTR_W-1:0]     wr_ptr;
    logic                 fill_high;
    logic [RES_W-1:0]     result_mem [BUF_WORDS];
    logic [2:0]           pin_sync;

    logic                 wr_c1;
    logic                 wr_c2;
    logic                 seq_event;
    logic [CH_W-1:0]      scan_chan;
    logic                 sel_trig;

    // first enabled scan channel at or after a start position, wrapping
    function automatic logic [CH_W-1:0] scan_pick(input logic [CH_W-1:0] start,
                                                  input logic [DATA_W-1:0] mask);
        logic [CH_W-1:0] idx;
        logic [CH_W-1:0] pick;
        logic            found;
        pick  = start;
        found = 1'b0;
        for (int k = 0; k < BUF_WORDS; k++) begin
            idx = start + CH_W'(k);
            if (!found && mask[idx]) begin
                pick  = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction : scan_pick

    // register address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
        return (a == reg_addr);
    endfunction : hit

    assign wr_c1     = wr_i && hit(addr_i, ADDR_CTRL1);
    assign wr_c2     = wr_i && hit(addr_i, ADDR_CTRL2);
    assign seq_event = sq.conv_finish && (seq_cnt == seq_per_irq);   // RULE10
    assign scan_chan = scan_pick(scan_ptr, scan_sel);                // RULE6

    // trigger pin synchroniser and rising edge
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], trig_pin_i};
        end
    end

    // pick the trigger pulse matching the source code
    always_comb begin
        unique case (trig_src)
            TRIG_PIN:               sel_trig = pin_sync[1] && !pin_sync[2];
            TRIG_TMR_A, TRIG_TMR_B: sel_trig = timer_trig_i;
            TRIG_EVT_A, TRIG_EVT_B: sel_trig = event_trig_i;
            default:                sel_trig = 1'b0;
        endcase
    end

    // drive the sequencer
    assign sq.set_samp   = wr_c1 && wdata_i[C1_SAMP] && !auto_start;     // RULE1
    assign sq.clr_samp   = wr_c1 && !wdata_i[C1_SAMP];                   // RULE2
    assign sq.auto_start = auto_start;
    assign sq.trig_src   = trig_src;
    assign sq.ext_trig   = sel_trig;
    assign sq.conv_ready = conv_ready_i;

    acp_sequencer #(
        .AUTO_SAMPLE_CYCLES (AUTO_SAMPLE_CYCLES)
    ) u_seq (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .sq     (sq)
    );

    // sample_convert_control writable fields
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            trig_src   <= TRIG_MANUAL;
            auto_start <= 1'b0;
        end else if (wr_c1) begin
            trig_src   <= wdata_i[C1_TRIG_MSB:C1_TRIG_LSB];
            auto_start <= wdata_i[C1_AUTO];
        end
    end

    // conversion done flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            done <= 1'b0;
        end else if (sq.conv_finish) begin
            done <= 1'b1;                                               // RULE17
        end else if (sq.conv_start || (wr_c1 && !wdata_i[C1_DONE])) begin
            done <= 1'b0;                                               // RULE17
        end
    end

    // conversion_setup_control writable fields
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ref_sel     <= REF_SUPPLY;
            scan_en     <= 1'b0;
            seq_per_irq <= 4'h0;
            split_mode  <= 1'b0;
            alt_mode    <= 1'b0;
        end else if (wr_c2) begin
            ref_sel     <= wdata_i[C2_REF_MSB:C2_REF_LSB];
            scan_en     <= wdata_i[C2_SCAN];
            seq_per_irq <= wdata_i[C2_SPI_MSB:C2_SPI_LSB];
            split_mode  <= wdata_i[C2_SPLIT];
            alt_mode    <= wdata_i[C2_ALT];
        end
    end

    // channel select, scan select and interrupt mask registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scan_sel <= 16'h0000;
            chan_a   <= 4'h0;
            chan_b   <= 4'h0;
            irq_mask <= 2'h0;
        end else if (wr_i) begin
            if (hit(addr_i, ADDR_SCAN_SEL)) begin
                scan_sel <= wdata_i;
            end
            if (hit(addr_i, ADDR_CH_SEL)) begin
                chan_a <= wdata_i[CH_A_LSB +: CH_W];
                chan_b <= wdata_i[CH_B_LSB +: CH_W];
            end
            if (hit(addr_i, ADDR_IRQ_MASK)) begin
                irq_mask <= wdata_i[IRQ_W-1:0];
            end
        end
    end

    // selector A/B alternation and scan position
    always_ff @(posedge clk_i) begin
        if (!nrst_i || wr_c2) begin
            on_sel_b <= 1'b0;                                           // RULE13
            scan_ptr <= 4'h0;
        end else if (sq.conv_finish) begin
            on_sel_b <= alt_mode && !on_sel_b;                          // RULE13 RULE14
            if (scan_en && !on_sel_b) begin
                scan_ptr <= scan_chan + 1'b1;                           // RULE6
            end
        end
    end

    // sequence counter, fill pointer and fill half
    always_ff @(posedge clk_i) begin
        if (!nrst_i || wr_c2) begin
            seq_cnt   <= 4'h0;
            wr_ptr    <= 4'h0;
            fill_high <= 1'b0;
        end else if (sq.conv_finish) begin
            if (seq_event) begin
                seq_cnt <= 4'h0;
                if (split_mode) begin
                    fill_high <= !fill_high;                            // RULE8 RULE9 RULE11
                    wr_ptr    <= {!fill_high, 3'h0};                    // RULE11
                end else begin
                    wr_ptr    <= 4'h0;                                  // RULE12
                end
            end else begin
                seq_cnt <= seq_cnt + 1'b1;
                if (split_mode) begin
                    wr_ptr <= {fill_high, wr_ptr[2:0] + 3'h1};          // RULE11
                end else begin
                    wr_ptr <= wr_ptr + 1'b1;                            // RULE12
                end
            end
        end
    end

    // result store
    always_ff @(posedge clk_i) begin
        if (conv_ready_i && sq.converting) begin
            result_mem[wr_ptr] <= conv_result_i;
        end
    end

    // sticky interrupt status, read clears, set wins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_stat <= 2'h0;
        end else begin
            for (int b = 0; b < IRQ_W; b++) begin
                if ((b == IRQ_SEQ && seq_event) || (b == IRQ_DONE && sq.conv_finish)) begin
                    irq_stat[b] <= 1'b1;                                // RULE10
                end else if (rd_i && hit(addr_i, ADDR_IRQ_STAT)) begin
                    irq_stat[b] <= 1'b0;
                end
            end
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= 16'h0000;
            if (addr_i[BUF_ADDR_BIT]) begin
                rdata_o[RES_W-1:0] <= result_mem[addr_i[PTR_W-1:0]];
            end else if (hit(addr_i, ADDR_CTRL1)) begin
                rdata_o[C1_TRIG_MSB:C1_TRIG_LSB] <= trig_src;
                rdata_o[C1_AUTO]                 <= auto_start;
                rdata_o[C1_SAMP]                 <= sq.sampling;        // RULE3
                rdata_o[C1_DONE]                 <= done;
            end else if (hit(addr_i, ADDR_CTRL2)) begin
                rdata_o[C2_REF_MSB:C2_REF_LSB]   <= ref_sel;
                rdata_o[C2_SCAN]                 <= scan_en;
                rdata_o[C2_HALF]                 <= split_mode && fill_high;  // RULE8 RULE9 RULE15
                rdata_o[C2_SPI_MSB:C2_SPI_LSB]   <= seq_per_irq;
                rdata_o[C2_SPLIT]                <= split_mode;
                rdata_o[C2_ALT]                  <= alt_mode;
            end else if (hit(addr_i, ADDR_SCAN_SEL)) begin
                rdata_o <= scan_sel;
            end else if (hit(addr_i, ADDR_CH_SEL)) begin
                rdata_o[CH_A_LSB +: CH_W] <= chan_a;
                rdata_o[CH_B_LSB +: CH_W] <= chan_b;
            end else if (hit(addr_i, ADDR_IRQ_STAT)) begin
                rdata_o[IRQ_W-1:0] <= irq_stat;
            end else if (hit(addr_i, ADDR_IRQ_MASK)) begin
                rdata_o[IRQ_W-1:0] <= irq_mask;
            end
        end
    end

    // analog front end controls
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            chan_pos_o    <= 4'h0;
            use_sel_b_o   <= 1'b0;
            ref_pos_ext_o <= 1'b0;
            ref_neg_ext_o <= 1'b0;
        end else begin
            use_sel_b_o   <= on_sel_b;                                  // RULE13 RULE14
            if (on_sel_b) begin
                chan_pos_o <= chan_b;
            end else begin
                chan_pos_o <= scan_en ? scan_chan : chan_a;             // RULE6 RULE7
            end
            ref_pos_ext_o <= (ref_sel == REF_EXT_POS) || (ref_sel == REF_EXT_BOTH);  // RULE4
            ref_neg_ext_o <= (ref_sel == REF_EXT_NEG) || (ref_sel == REF_EXT_BOTH);  // RULE4
        end
    end

    // sequencer state and interrupt level
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sampling_o   <= 1'b0;
            converting_o <= 1'b0;
            irq_o        <= 1'b0;
        end else begin
            sampling_o   <= sq.sampling;
            converting_o <= sq.converting;
            irq_o        <= |(irq_stat & irq_mask);
        end
    end
endmodule : acp_ctrl

// ### hdl/acp_pkg.sv
/*
 * acp_pkg: shared constants and types of the sample/convert control block.
 * Assumes a 16-bit plain register port and a 10-bit converter core on the same clock.
 */
package acp_pkg;
    // register port geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int RES_W  = 10;
    localparam int BUF_WORDS = 16;
    localparam int PTR_W  = 4;
    localparam int CH_W   = 4;

    // register addresses (word indices)
    localparam logic [ADDR_W-1:0] ADDR_CTRL1    = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL2    = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_SCAN_SEL = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_CH_SEL   = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h05;
    localparam int                BUF_ADDR_BIT  = 4;      // address bit 4 set selects result words

    // sample_convert_control fields
    localparam int C1_TRIG_LSB = 5;
    localparam int C1_TRIG_MSB = 7;
    localparam int C1_AUTO     = 2;
    localparam int C1_SAMP     = 1;
    localparam int C1_DONE     = 0;

    // conversion_setup_control fields
    localparam int C2_REF_LSB  = 13;
    localparam int C2_REF_MSB  = 15;
    localparam int C2_RSVD     = 12;
    localparam int C2_SCAN     = 10;
    localparam int C2_HALF     = 7;
    localparam int C2_SPI_LSB  = 2;
    localparam int C2_SPI_MSB  = 5;
    localparam int C2_SPLIT    = 1;
    localparam int C2_ALT      = 0;

    // channel select register fields
    localparam int CH_A_LSB = 0;
    localparam int CH_B_LSB = 8;

    // interrupt status / mask bits
    localparam int IRQ_W       = 2;
    localparam int IRQ_SEQ     = 0;
    localparam int IRQ_DONE    = 1;

    // trigger source codes
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_PIN    = 3'h1;
    localparam logic [2:0] TRIG_TMR_A  = 3'h2;
    localparam logic [2:0] TRIG_TMR_B  = 3'h3;
    localparam logic [2:0] TRIG_EVT_A  = 3'h4;
    localparam logic [2:0] TRIG_EVT_B  = 3'h6;
    localparam logic [2:0] TRIG_AUTO   = 3'h7;

    // reference select codes
    localparam logic [2:0] REF_SUPPLY  = 3'h0;
    localparam logic [2:0] REF_EXT_POS = 3'h1;
    localparam logic [2:0] REF_EXT_NEG = 3'h2;
    localparam logic [2:0] REF_EXT_BOTH = 3'h3;

    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int AUTO_SAMPLE_NS  = 1000;
    localparam int AUTO_SAMPLE_CYC = (AUTO_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMP_CNT_W      = 8;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_CONVERT
    } acp_seq_state_t;
endpackage : acp_pkg

// ### hdl/acp_seq_if.sv
/*
 * acp_seq_if: bundle between the register side and the sample/convert sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface acp_seq_if;
    logic       set_samp;     // software wrote sample bit to one
    logic       clr_samp;     // software wrote sample bit to zero
    logic       auto_start;
    logic [2:0] trig_src;
    logic       ext_trig;     // one-cycle trigger for the selected source
    logic       conv_ready;   // converter core finished
    logic       sampling;
    logic       converting;
    logic       conv_start;   // one-cycle pulse
    logic       conv_finish;  // one-cycle pulse

    modport ctl (output set_samp, output clr_samp, output auto_start, output trig_src,
                 output ext_trig, output conv_ready,
                 input sampling, input converting, input conv_start, input conv_finish);
    modport seq (input set_samp, input clr_samp, input auto_start, input trig_src,
                 input ext_trig, input conv_ready,
                 output sampling, output converting, output conv_start, output conv_finish);
endinterface : acp_seq_if

// ### hdl/acp_sequencer.sv
/*
 * acp_sequencer: sample / hold / convert state machine.
 * Assumes the converter core reports completion with a one-cycle pulse.
 */
`timescale 1ns/1ps
module acp_sequencer
    import acp_pkg::*;
#(
    parameter int AUTO_SAMPLE_CYCLES = AUTO_SAMPLE_CYC
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    acp_seq_if.seq    sq
);
    acp_seq_state_t            state;
    acp_seq_state_t            next_state;
    logic [SAMP_CNT_W-1:0]     samp_cnt;
    logic                      end_sample;

    localparam logic [SAMP_CNT_W-1:0] SAMP_LAST = SAMP_CNT_W'(AUTO_SAMPLE_CYCLES - 1);

    // event that ends sampling, chosen by trigger source
    always_comb begin
        unique case (sq.trig_src)
            TRIG_MANUAL: end_sample = sq.clr_samp;                 // RULE2 RULE16
            TRIG_AUTO:   end_sample = (samp_cnt == SAMP_LAST);      // RULE16
            TRIG_PIN, TRIG_TMR_A, TRIG_TMR_B, TRIG_EVT_A, TRIG_EVT_B: end_sample = sq.ext_trig;
            default:     end_sample = 1'b0;                        // reserved code never converts
        endcase
    end

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            SEQ_IDLE: begin
                if ((sq.set_samp && !sq.auto_start) || sq.auto_start) begin
                    next_state = SEQ_SAMPLE;                        // RULE1
                end
            end
            SEQ_SAMPLE: begin
                if (end_sample) begin
                    next_state = SEQ_CONVERT;
                end
            end
            SEQ_CONVERT: begin
                if (sq.conv_ready) begin
                    next_state = sq.auto_start ? SEQ_SAMPLE : SEQ_IDLE;
                end
            end
        endcase
    end

    // state register and status flops
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state          <= SEQ_IDLE;
            sq.sampling    <= 1'b0;
            sq.converting  <= 1'b0;
            sq.conv_start  <= 1'b0;
            sq.conv_finish <= 1'b0;
        end else begin
            state          <= next_state;
            sq.sampling    <= (next_state == SEQ_SAMPLE);           // RULE3
            sq.converting  <= (next_state == SEQ_CONVERT);
            sq.conv_start  <= (state == SEQ_SAMPLE) && (next_state == SEQ_CONVERT);
            sq.conv_finish <= (state == SEQ_CONVERT) && sq.conv_ready;
        end
    end

    // sample time counter for the automatic trigger
    always_ff @(posedge clk_i) begin
        if (!nrst_i || state != SEQ_SAMPLE) begin
            samp_cnt <= '0;
        end else if (samp_cnt != SAMP_LAST) begin
            samp_cnt <= samp_cnt + 1'b1;
        end
    end
endmodule : acp_sequencer

// ### tb/acp_ctrl_properties.sv
/* acp_ctrl_properties: port-level checks of the sample/convert control block.
   Assumes it is bound to acp_ctrl and sees only that module's ports. */
`timescale 1ns/1ps
module acp_ctrl_checker
    import acp_pkg::*;
#(
    parameter int AUTO_SAMPLE_CYCLES = AUTO_SAMPLE_CYC
) (
    input wire logic              clk_i,
    input wire logic              nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              conv_ready_i,
    input wire logic              sampling_o,
    input wire logic              converting_o,
    input wire logic              ref_pos_ext_o,
    input wire logic              ref_neg_ext_o,
    input wire logic              irq_o
);
    logic [2:0] last_ref;
    // last reference code written by software
    always_ff @(posedge clk_i) begin
        if (wr_i && addr_i == ADDR_CTRL2) begin
            last_ref <= wdata_i[15:13];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ref_map_a: assert property ((wr_i && addr_i == ADDR_CTRL2) ##1 !(wr_i && addr_i == ADDR_CTRL2) |=>
        ref_pos_ext_o == (last_ref inside {3'h1, 3'h3}) && ref_neg_ext_o == (last_ref inside {3'h2, 3'h3}))
        else $error("reference outputs do not follow the written code");
    start_samp_a: assert property (wr_i && addr_i == ADDR_CTRL1 && wdata_i[1] && !wdata_i[2] && !sampling_o
        && !converting_o && !$past(wr_i && addr_i == ADDR_CTRL1) |-> ##2 sampling_o)
        else $error("sample request did not start acquisition");
    end_samp_a: assert property (wr_i && addr_i == ADDR_CTRL1 && wdata_i[7:5] == TRIG_MANUAL && !wdata_i[1]
        && sampling_o |-> ##2 converting_o && !sampling_o)
        else $error("clearing the sample bit did not start a conversion");
    conv_end_a: assert property ($fell(converting_o) |-> $past(conv_ready_i, 2))
        else $error("conversion ended without a ready pulse");
    conv_hold_a: assert property (converting_o && conv_ready_i |-> ##1 converting_o ##1 !converting_o)
        else $error("conversion did not end two cycles after ready");
    irq_cause_a: assert property ($rose(irq_o) && !$past(wr_i && addr_i == ADDR_IRQ_MASK, 2)
        |-> $past(conv_ready_i, 3))
        else $error("interrupt rose without a finished conversion");
    samp_read_a: assert property (rd_i && addr_i == ADDR_CTRL1 |=> rdata_o[1] == sampling_o)
        else $error("sample bit read back differs from acquisition state");
    one_phase_a: assert property (!(sampling_o && converting_o))
        else $error("sampling and converting at once");
    unmapped_a: assert property (rd_i && addr_i >= 5'h06 && addr_i <= 5'h0F |=> rdata_o == 16'h0000)
        else $error("unmapped address read nonzero");
    reset_quiet_a: assert property (disable iff (1'b0) !nrst_i |=> !sampling_o && !converting_o && !irq_o)
        else $error("outputs active after reset");
endmodule : acp_ctrl_checker

bind acp_ctrl acp_ctrl_checker #(.AUTO_SAMPLE_CYCLES(AUTO_SAMPLE_CYCLES)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_ready_i(conv_ready_i),
    .sampling_o(sampling_o), .converting_o(converting_o), .ref_pos_ext_o(ref_pos_ext_o),
    .ref_neg_ext_o(ref_neg_ext_o), .irq_o(irq_o));

// ### tb/test_adc_sample_convert_control.sv
/* test_adc_sample_convert_control: register-port tests of the sample/convert block.
   Assumes the trigger pins stay idle; the bench plays the converter core. */
`timescale 1ns/1ps
module test_adc_sample_convert_control;
    import acp_pkg::*;
    logic              clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, conv_ready_i = 0, mask_on = 0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic [RES_W-1:0]  conv_result_i = '0;
    logic [DATA_W-1:0] rdata_o;
    logic [CH_W-1:0]   chan_pos_o;
    logic              sampling_o, converting_o, use_sel_b_o, ref_pos_ext_o, ref_neg_ext_o, irq_o;
    int                mismatches = 0, n_compared = 0, cycles = 0;
    acp_ctrl #(.AUTO_SAMPLE_CYCLES(3)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_pin_i(1'b0), .timer_trig_i(1'b0), .event_trig_i(1'b0),
        .conv_ready_i(conv_ready_i), .conv_result_i(conv_result_i), .sampling_o(sampling_o),
        .converting_o(converting_o), .chan_pos_o(chan_pos_o), .use_sel_b_o(use_sel_b_o),
        .ref_pos_ext_o(ref_pos_ext_o), .ref_neg_ext_o(ref_neg_ext_o), .irq_o(irq_o));
    // clock and hang guard
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o & m, e);
    endtask : rd
    // one sample/convert sequence; seq says whether it completes an interrupt group
    task automatic conv(input logic [2:0] code, input logic [3:0] ch, input logic b, input logic [9:0] res,
                        input logic seq);
        wr(ADDR_CTRL1, {8'h00, code, 5'h02});
        repeat (6) @(posedge clk_i);
        #1;
        chk(sampling_o, code == TRIG_MANUAL);
        if (code == TRIG_MANUAL) begin
            rd(ADDR_CTRL1, 16'h0002, 16'h0003);
            wr(ADDR_CTRL1, 16'h0000);
        end
        for (int i = 0; i < 10 && converting_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(converting_o, 1'b1);
        chk(chan_pos_o, ch);
        chk(use_sel_b_o, b);
        @(posedge clk_i);
        conv_ready_i <= 1'b1;
        conv_result_i <= res;
        @(posedge clk_i);
        conv_ready_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(irq_o, seq & mask_on);
        rd(ADDR_CTRL1, 16'h0001, 16'h0003);
        wr(ADDR_CTRL1, 16'h0000);
        rd(ADDR_CTRL1, 16'h0000, 16'h0003);
        rd(ADDR_IRQ_STAT, {15'h0000, seq}, 16'h0001);
    endtask : conv
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(ADDR_CTRL1, 16'h0000, 16'hFFFF);
        rd(ADDR_CTRL2, 16'h0000, 16'hFFFF);
        wr(5'h06, 16'hFFFF);
        rd(5'h06, 16'h0000, 16'hFFFF);
        wr(ADDR_CH_SEL, 16'h0905);
        conv(TRIG_MANUAL, 4'h5, 1'b0, 10'h155, 1'b1);
        rd(5'h10, 16'h0155, 16'hFFFF);
        wr(ADDR_IRQ_MASK, 16'h0001);
        mask_on = 1'b1;
        wr(ADDR_CTRL2, 16'h0005);
        conv(TRIG_MANUAL, 4'h5, 1'b0, 10'h0AA, 1'b0);
        conv(TRIG_AUTO, 4'h9, 1'b1, 10'h3C3, 1'b1);
        rd(5'h11, 16'h03C3, 16'hFFFF);
        rd(ADDR_CTRL2, 16'h0000, 16'h0080);
        wr(ADDR_SCAN_SEL, 16'h0003);
        wr(ADDR_CTRL2, 16'h0400);
        conv(TRIG_MANUAL, 4'h0, 1'b0, 10'h001, 1'b1);
        conv(TRIG_MANUAL, 4'h1, 1'b0, 10'h002, 1'b1);
        wr(ADDR_CTRL2, 16'h0002);
        rd(ADDR_CTRL2, 16'h0000, 16'h0080);
        conv(TRIG_MANUAL, 4'h5, 1'b0, 10'h111, 1'b1);
        rd(ADDR_CTRL2, 16'h0080, 16'h0080);
        rd(5'h10, 16'h0111, 16'hFFFF);
        conv(TRIG_MANUAL, 4'h5, 1'b0, 10'h222, 1'b1);
        rd(ADDR_CTRL2, 16'h0000, 16'h0080);
        rd(5'h18, 16'h0222, 16'hFFFF);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTRL2, {c[2:0], 13'h0000});
            rd(ADDR_CTRL2, {c[2:0], 13'h0000}, 16'hF000);
            chk({ref_pos_ext_o, ref_neg_ext_o}, c[2] ? 2'b00 : {c[0], c[1]});
        end
        conclude();
    end
endmodule : test_adc_sample_convert_control
